// ===== rwps_defs.vh
// Constants for the reset, wake and pin sequencer
`ifndef RWPS_DEFS_VH
`define RWPS_DEFS_VH

// ------------------------------------------------------------
// Clock and timing
// ------------------------------------------------------------
`define RWPS_CLK_PERIOD_NS    40
`define RWPS_RST_MIN_PERIODS  3
`define RWPS_POST_RST_PERIODS 38
`define RWPS_INT_HIGH_PERIODS 2
`define RWPS_INT_LOW_PERIODS  3
`define RWPS_WAKE_LOW_PERIODS 3
`define RWPS_CLKGEN_WAKE_US   1250
`define RWPS_CLKGEN_WAKE_CYC  ((`RWPS_CLKGEN_WAKE_US * 1000 + `RWPS_CLK_PERIOD_NS - 1) / `RWPS_CLK_PERIOD_NS)

// ------------------------------------------------------------
// Reset values of the high and float pin groups
// ------------------------------------------------------------
`define RWPS_HIGH_GROUP_RST   1'b1
`define RWPS_FLOAT_OE_RST     1'b0

// ------------------------------------------------------------
// Sequencer state codes
// ------------------------------------------------------------
`define RWPS_ST_RESET         3'h0
`define RWPS_ST_RELEASE       3'h1
`define RWPS_ST_RUN           3'h2
`define RWPS_ST_CPU_IDLE      3'h3
`define RWPS_ST_CLK_IDLE      3'h4
`define RWPS_ST_CLK_START     3'h5

`endif

// ===== rwps_pulse_qual.v
// Qualifier for one active-low interrupt or wake line
`timescale 1ns/1ps
`include "rwps_defs.vh"

module rwps_pulse_qual #(
  parameter HIGH_MIN = `RWPS_INT_HIGH_PERIODS,
  parameter LOW_MIN  = `RWPS_INT_LOW_PERIODS
) (
  // Clock and reset
  input  wire clk_in,
  input  wire rst_n_in,
  // Line and mode
  input  wire line_n_in,
  input  wire level_mode_in,
  // Results
  output reg  edge_pulse_out,
  output reg  level_pulse_out,
  output wire low_ok_out
);

  reg       sync1_q;
  reg       sync2_q;
  reg [2:0] hi_cnt_q;
  reg [2:0] lo_cnt_q;
  reg [2:0] rep_cnt_q;
  reg       armed_q;

  assign low_ok_out = (lo_cnt_q >= LOW_MIN[2:0]);

  // ------------------------------------------------------------
  // Two-stage synchroniser and qualification counters
  // ------------------------------------------------------------
  always @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_q         <= 1'b1;
      sync2_q         <= 1'b1;
      hi_cnt_q        <= 3'h0;
      lo_cnt_q        <= 3'h0;
      rep_cnt_q       <= 3'h0;
      armed_q         <= 1'b0;
      edge_pulse_out  <= 1'b0;
      level_pulse_out <= 1'b0;
    end else begin
      sync1_q         <= line_n_in; // [RQ13]
      sync2_q         <= sync1_q;
      edge_pulse_out  <= 1'b0;
      level_pulse_out <= 1'b0;
      if (sync2_q) begin
        lo_cnt_q  <= 3'h0;
        rep_cnt_q <= 3'h0;
        if (hi_cnt_q != 3'h7)
          hi_cnt_q <= hi_cnt_q + 3'h1;
        if (hi_cnt_q + 3'h1 >= HIGH_MIN[2:0])
          armed_q <= 1'b1;
      end else begin
        hi_cnt_q <= 3'h0;
        if (lo_cnt_q != 3'h7)
          lo_cnt_q <= lo_cnt_q + 3'h1;
        // High then low long enough signals once
        if (armed_q && lo_cnt_q + 3'h1 == LOW_MIN[2:0]) begin // [RQ13]
          edge_pulse_out <= 1'b1;
          armed_q        <= 1'b0;
        end
        // Level mode repeats every qualified low span; own count so
        // the low length seen by the wake logic keeps growing until it saturates at 7
        if (level_mode_in) begin
          if (rep_cnt_q + 3'h1 >= LOW_MIN[2:0]) begin // [RQ12]
            level_pulse_out <= 1'b1;
            rep_cnt_q       <= 3'h0;
          end else begin
            rep_cnt_q <= rep_cnt_q + 3'h1;
          end
        end else begin
          rep_cnt_q <= 3'h0;
        end
      end
    end
  end

endmodule // rwps_pulse_qual

// ===== rwps_sequencer.v
// Reset, pin group, interrupt and wake sequencer
// Contract
// RQ1 - Board holds reset three input clocks post-oscillator
// RQ2 - Bypass: reset low three clocks after valid
// RQ3 - Warm reset needs three CPU clocks low
// RQ4 - Keeper pins hold during reset, release within 38
// RQ5 - Host interrupt and flag high within 38
// RQ6 - Float pins tristate within 38 after reset
// RQ7 - Float pins stop driving one clock after fall
// RQ8 - Interrupt needs two high, three low periods
// RQ9 - CPU-idle wake needs three low periods
// RQ10 - Clock-idle wake restarts clock after 1.25 ms
// RQ11 - Wake stays low three periods after restart
// RQ12 - After clock idle, interrupt level-sensitive until rise
// RQ13 - Inputs synchronised, interrupt qualified high then low
`timescale 1ns/1ps
`include "rwps_defs.vh"

module rwps_sequencer #(
  parameter NUM_INT     = 2,
  parameter KEEP_W      = 16,
  parameter FLOAT_W     = 8,
  parameter POST_RST    = `RWPS_POST_RST_PERIODS,
  parameter CLKGEN_WAKE = `RWPS_CLKGEN_WAKE_CYC
) (
  // Clock and reset
  input  wire               REF_CLK_IN,
  input  wire               RESETN_IN,
  // Board reset pin
  input  wire               EXT_RESET_N_IN,
  // External interrupt and wake lines
  input  wire [NUM_INT-1:0] EXT_INTERRUPT_N_IN,
  // Core side requests
  input  wire               CPU_IDLE_REQ_IN,
  input  wire               CLK_IDLE_REQ_IN,
  input  wire               FLAG_SET_IN,
  input  wire               FLAG_CLR_IN,
  input  wire               HOST_INT_REQ_IN,
  input  wire [KEEP_W-1:0]  KEEP_DATA_IN,
  input  wire [FLOAT_W-1:0] FLOAT_DATA_IN,
  input  wire [FLOAT_W-1:0] FLOAT_OE_IN,
  // Core side status
  output reg                CORE_RESET_N_OUT,
  output reg                CPU_CLK_EN_OUT,
  output reg                CLKGEN_EN_OUT,
  output reg  [NUM_INT-1:0] CORE_INT_OUT,
  // Pin groups
  output reg  [KEEP_W-1:0]  KEEP_PIN_OUT,
  output reg                HOST_INTERRUPT_OUT,
  output reg                FLAG_OUTPUT_OUT,
  output reg  [FLOAT_W-1:0] FLOAT_PIN_OUT,
  output reg  [FLOAT_W-1:0] FLOAT_PIN_OE_OUT
);

  reg  [2:0]  state_q;
  reg  [2:0]  state_d;
  reg         rst_s1_q;
  reg         rst_s2_q;
  reg  [1:0]  rst_lo_cnt_q;
  reg  [5:0]  post_cnt_q;
  reg  [31:0] wake_cnt_q;
  reg  [NUM_INT-1:0] level_mode_q;
  reg  [NUM_INT-1:0] int_n_s_q;
  wire [NUM_INT-1:0] edge_p;
  wire [NUM_INT-1:0] level_p;
  wire [NUM_INT-1:0] low_ok;
  wire        warm_rst;
  wire        any_wake;
  wire        in_reset_d;

  // ------------------------------------------------------------
  // Warm reset recognition
  // ------------------------------------------------------------
  // Pulses shorter than three clocks are ignored as glitches
  assign warm_rst = !rst_s2_q && (rst_lo_cnt_q == 2'h2); // [RQ3]
  assign any_wake = |low_ok;

  always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      rst_s1_q     <= 1'b0;
      rst_s2_q     <= 1'b0;
      rst_lo_cnt_q <= 2'h0;
    end else begin
      rst_s1_q <= EXT_RESET_N_IN; // [RQ13]
      rst_s2_q <= rst_s1_q;
      if (rst_s2_q)
        rst_lo_cnt_q <= 2'h0;
      else if (rst_lo_cnt_q != 2'h3)
        rst_lo_cnt_q <= rst_lo_cnt_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Interrupt qualifiers
  // ------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_INT; gi = gi + 1) begin : g_int
      rwps_pulse_qual #(
        .HIGH_MIN (`RWPS_INT_HIGH_PERIODS),
        .LOW_MIN  (`RWPS_INT_LOW_PERIODS)
      ) u_qual (
        .clk_in          (REF_CLK_IN),
        .rst_n_in        (RESETN_IN),
        .line_n_in       (EXT_INTERRUPT_N_IN[gi]),
        .level_mode_in   (level_mode_q[gi]),
        .edge_pulse_out  (edge_p[gi]),
        .level_pulse_out (level_p[gi]),
        .low_ok_out      (low_ok[gi])
      );

      // Level mode ends at the first rise after wake
      always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
        if (!RESETN_IN) begin
          level_mode_q[gi] <= 1'b0;
          int_n_s_q[gi]    <= 1'b1;
        end else begin
          int_n_s_q[gi] <= low_ok[gi] ? 1'b0 : 1'b1;
          if (state_q == `RWPS_ST_CLK_IDLE)
            level_mode_q[gi] <= 1'b1; // [RQ12]
          else if (state_q == `RWPS_ST_RUN && !low_ok[gi] && !int_n_s_q[gi])
            level_mode_q[gi] <= 1'b0; // [RQ12]
        end
      end
    end
  endgenerate

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      `RWPS_ST_RESET:     if (rst_s2_q) state_d = `RWPS_ST_RELEASE;
      `RWPS_ST_RELEASE:   if (post_cnt_q == POST_RST[5:0] - 6'h1) state_d = `RWPS_ST_RUN;
      `RWPS_ST_RUN: begin
        if (CLK_IDLE_REQ_IN)
          state_d = `RWPS_ST_CLK_IDLE;
        else if (CPU_IDLE_REQ_IN)
          state_d = `RWPS_ST_CPU_IDLE;
      end
      // CPU-only idle wakes on a qualified three-clock low
      `RWPS_ST_CPU_IDLE:  if (any_wake) state_d = `RWPS_ST_RUN; // [RQ9]
      `RWPS_ST_CLK_IDLE:  if (any_wake) state_d = `RWPS_ST_CLK_START; // [RQ10]
      // Oscillator restart time is modelled as a fixed wait
      `RWPS_ST_CLK_START: if (wake_cnt_q >= CLKGEN_WAKE) state_d = `RWPS_ST_RUN; // [RQ10]
      default:            state_d = `RWPS_ST_RESET;
    endcase
    if (warm_rst)
      state_d = `RWPS_ST_RESET;
  end

  // Core held while the next state is reset or release
  assign in_reset_d = (state_d == `RWPS_ST_RESET) || (state_d == `RWPS_ST_RELEASE);

  always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      state_q    <= `RWPS_ST_RESET;
      post_cnt_q <= 6'h0;
      wake_cnt_q <= 32'h0;
    end else begin
      state_q <= state_d;
      if (state_q == `RWPS_ST_RELEASE)
        post_cnt_q <= post_cnt_q + 6'h1;
      else
        post_cnt_q <= 6'h0;
      if (state_q == `RWPS_ST_CLK_START)
        wake_cnt_q <= wake_cnt_q + 32'h1;
      else
        wake_cnt_q <= 32'h0;
    end
  end

  // ------------------------------------------------------------
  // Pin groups and core outputs
  // ------------------------------------------------------------
  always @(posedge REF_CLK_IN or negedge RESETN_IN) begin
    if (!RESETN_IN) begin
      CORE_RESET_N_OUT   <= 1'b0;
      CPU_CLK_EN_OUT     <= 1'b1;
      CLKGEN_EN_OUT      <= 1'b1;
      CORE_INT_OUT       <= {NUM_INT{1'b0}};
      KEEP_PIN_OUT       <= {KEEP_W{1'b0}};
      HOST_INTERRUPT_OUT <= `RWPS_HIGH_GROUP_RST;
      FLAG_OUTPUT_OUT    <= `RWPS_HIGH_GROUP_RST;
      FLOAT_PIN_OUT      <= {FLOAT_W{1'b0}};
      FLOAT_PIN_OE_OUT   <= {FLOAT_W{`RWPS_FLOAT_OE_RST}};
    end else begin
      CORE_RESET_N_OUT <= !in_reset_d;
      CPU_CLK_EN_OUT   <= (state_d != `RWPS_ST_CPU_IDLE) && (state_d != `RWPS_ST_CLK_IDLE)
                          && (state_d != `RWPS_ST_CLK_START);
      CLKGEN_EN_OUT    <= (state_d != `RWPS_ST_CLK_IDLE);
      // Next state gates delivery, so a wake interrupt reaches the woken core
      CORE_INT_OUT     <= (state_d == `RWPS_ST_RUN) ? (edge_p | level_p) : {NUM_INT{1'b0}};
      // Raw pin meets the one-clock drop; the synchronised copy is two late
      if (!EXT_RESET_N_IN || in_reset_d) begin
        FLOAT_PIN_OE_OUT <= {FLOAT_W{`RWPS_FLOAT_OE_RST}}; // [RQ7] [RQ6]
      end else begin
        FLOAT_PIN_OE_OUT <= FLOAT_OE_IN;
        FLOAT_PIN_OUT    <= FLOAT_DATA_IN;
      end
      // High group moves on the same edge as the core reset
      if (in_reset_d) begin
        HOST_INTERRUPT_OUT <= `RWPS_HIGH_GROUP_RST; // [RQ5]
        FLAG_OUTPUT_OUT    <= `RWPS_HIGH_GROUP_RST; // [RQ5]
      end else begin
        HOST_INTERRUPT_OUT <= !HOST_INT_REQ_IN;
        if (FLAG_SET_IN)
          FLAG_OUTPUT_OUT <= 1'b1;
        else if (FLAG_CLR_IN)
          FLAG_OUTPUT_OUT <= 1'b0;
      end
      // Keeper pins hold through reset, then settle to zero
      if (state_q == `RWPS_ST_RESET)
        KEEP_PIN_OUT <= KEEP_PIN_OUT; // [RQ4]
      else if (state_q == `RWPS_ST_RELEASE)
        KEEP_PIN_OUT <= {KEEP_W{1'b0}}; // [RQ4]
      else
        KEEP_PIN_OUT <= KEEP_DATA_IN;
    end
  end

endmodule // rwps_sequencer

// ===== rwps_properties.sv
// Checker for the reset, wake and pin sequencer ports
`timescale 1ns/1ps
module rwps_properties #(
  parameter NUM_INT  = 2,
  parameter KEEP_W   = 16,
  parameter FLOAT_W  = 8,
  parameter POST_RST = 38
) (
  input wire               REF_CLK_IN,
  input wire               RESETN_IN,
  input wire               EXT_RESET_N_IN,
  input wire [NUM_INT-1:0] EXT_INTERRUPT_N_IN,
  input wire               CORE_RESET_N_OUT,
  input wire               CPU_CLK_EN_OUT,
  input wire               CLKGEN_EN_OUT,
  input wire [NUM_INT-1:0] CORE_INT_OUT,
  input wire [KEEP_W-1:0]  KEEP_PIN_OUT,
  input wire               HOST_INTERRUPT_OUT,
  input wire               FLAG_OUTPUT_OUT,
  input wire [FLOAT_W-1:0] FLOAT_PIN_OE_OUT
);
  // Sync, release count and run-state register margin
  localparam int RLS_MAX = POST_RST + 8;
  default clocking @(posedge REF_CLK_IN); endclocking
  default disable iff (!RESETN_IN);
  a_float_drop: assert property ($fell(EXT_RESET_N_IN) |-> ##1 FLOAT_PIN_OE_OUT == 0)
    else $error("float pins still driven after reset fall");
  a_float_hiz: assert property (!CORE_RESET_N_OUT |-> FLOAT_PIN_OE_OUT == 0)
    else $error("float pins driven in reset");
  a_high_group: assert property (!CORE_RESET_N_OUT |-> HOST_INTERRUPT_OUT && FLAG_OUTPUT_OUT)
    else $error("high group low in reset");
  a_keep_hold: assert property (!EXT_RESET_N_IN && !CORE_RESET_N_OUT && !$past(CORE_RESET_N_OUT)
    |-> $stable(KEEP_PIN_OUT))
    else $error("keeper pins moved in reset");
  a_release_time: assert property ($rose(EXT_RESET_N_IN) && !CORE_RESET_N_OUT
    |-> ##[1:RLS_MAX] CORE_RESET_N_OUT)
    else $error("release too slow");
  a_int_in_run: assert property (CORE_INT_OUT != 0 |-> CORE_RESET_N_OUT && CPU_CLK_EN_OUT)
    else $error("interrupt outside run");
  a_int_single: assert property (CORE_INT_OUT[0] |=> !CORE_INT_OUT[0])
    else $error("interrupt pulse too long");
  a_int_cause: assert property ($rose(CORE_INT_OUT[0]) |-> !$past(EXT_INTERRUPT_N_IN[0], 6))
    else $error("interrupt without low line");
  a_clk_restart: assert property ($rose(CLKGEN_EN_OUT)
    |-> (!CPU_CLK_EN_OUT) [*8] ##[1:6] CPU_CLK_EN_OUT)
    else $error("cpu clock restart out of window");
endmodule // rwps_properties

bind rwps_sequencer rwps_properties #(
  .NUM_INT(NUM_INT), .KEEP_W(KEEP_W), .FLOAT_W(FLOAT_W), .POST_RST(POST_RST)
) u_rwps_properties (
  .REF_CLK_IN(REF_CLK_IN), .RESETN_IN(RESETN_IN), .EXT_RESET_N_IN(EXT_RESET_N_IN),
  .EXT_INTERRUPT_N_IN(EXT_INTERRUPT_N_IN), .CORE_RESET_N_OUT(CORE_RESET_N_OUT),
  .CPU_CLK_EN_OUT(CPU_CLK_EN_OUT), .CLKGEN_EN_OUT(CLKGEN_EN_OUT),
  .CORE_INT_OUT(CORE_INT_OUT), .KEEP_PIN_OUT(KEEP_PIN_OUT),
  .HOST_INTERRUPT_OUT(HOST_INTERRUPT_OUT), .FLAG_OUTPUT_OUT(FLAG_OUTPUT_OUT),
  .FLOAT_PIN_OE_OUT(FLOAT_PIN_OE_OUT)
);

// ===== rwps_board.sv
// Board reset circuit and interrupt source model
`timescale 1ns/1ps
module rwps_board (
  input  wire       clk_in,
  output reg        rst_n_out,
  output reg  [1:0] int_n_out
);
  initial begin
    rst_n_out = 1'b0;
    int_n_out = 2'h3;
  end
  // Callers keep n at 3 or more
  task hold_reset(input integer n);
    begin
      @(posedge clk_in) rst_n_out <= 1'b0;
      repeat (n) @(posedge clk_in);
      rst_n_out <= 1'b1;
    end
  endtask
  task pulse(input integer k, input integer hi, input integer lo);
    begin
      @(posedge clk_in) int_n_out[k] <= 1'b1;
      repeat (hi) @(posedge clk_in);
      int_n_out[k] <= 1'b0;
      repeat (lo) @(posedge clk_in);
      int_n_out[k] <= 1'b1;
    end
  endtask
endmodule // rwps_board

// ===== rwps_sequencer_bench.sv
// Self-checking bench for the reset, wake and pin sequencer
`timescale 1ns/1ps
module rwps_sequencer_bench;
  reg         clk = 1'b0, rst_n = 1'b0, cpu_idle = 1'b0, clk_idle = 1'b0;
  reg         f_set = 1'b0, f_clr = 1'b0, h_req = 1'b0, ef = 1'b1;
  reg  [15:0] keep_d = 16'h0000, kv;
  reg  [7:0]  fl_d = 8'h00, fl_oe = 8'h00, r = 8'h3C;
  wire        ext_rst_n, core_rst_n, cpu_en, gen_en, host, flag;
  wire [1:0]  ext_int_n, core_int;
  wire [15:0] keep;
  wire [7:0]  fl_pin, fl_pin_oe;
  integer     failures = 0, num_checks = 0, cyc = 0, n, i;
  // Short release and restart counts keep the run brief
  rwps_sequencer #(.POST_RST(4), .CLKGEN_WAKE(10)) u_rwps_sequencer (
    .REF_CLK_IN(clk), .RESETN_IN(rst_n), .EXT_RESET_N_IN(ext_rst_n),
    .EXT_INTERRUPT_N_IN(ext_int_n), .CPU_IDLE_REQ_IN(cpu_idle), .CLK_IDLE_REQ_IN(clk_idle),
    .FLAG_SET_IN(f_set), .FLAG_CLR_IN(f_clr), .HOST_INT_REQ_IN(h_req),
    .KEEP_DATA_IN(keep_d), .FLOAT_DATA_IN(fl_d), .FLOAT_OE_IN(fl_oe),
    .CORE_RESET_N_OUT(core_rst_n), .CPU_CLK_EN_OUT(cpu_en), .CLKGEN_EN_OUT(gen_en),
    .CORE_INT_OUT(core_int), .KEEP_PIN_OUT(keep), .HOST_INTERRUPT_OUT(host),
    .FLAG_OUTPUT_OUT(flag), .FLOAT_PIN_OUT(fl_pin), .FLOAT_PIN_OE_OUT(fl_pin_oe));
  rwps_board u_rwps_board (.clk_in(clk), .rst_n_out(ext_rst_n), .int_n_out(ext_int_n));
  always #20 clk = ~clk;
  function [7:0] nx(input [7:0] v);
    nx = {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
  endfunction
  task check(input [17:0] seen, input [17:0] exp);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        failures = failures + 1;
        $display("CHECK FAILED at %0t: saw %h want %h", $time, seen, exp);
      end
    end
  endtask
  task results;
    begin
      $display("checks %0d mismatches %0d", num_checks, failures);
      if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
    end
  endtask
  task tick(input integer k);
    begin
      repeat (k) @(posedge clk);
      #1;
    end
  endtask
  task await_run;
    begin
      n = 0;
      while (core_rst_n !== 1'b1 && n < 14) begin
        tick(1);
        n = n + 1;
      end
      check(core_rst_n, 1'b1);
    end
  endtask
  // Counts core interrupt pulses on one line over w clocks from the start of a board pulse
  task int_seq(input integer k, input integer lo, input integer w);
    fork
      u_rwps_board.pulse(k, 2, lo);
      begin
        n = 0;
        repeat (w) begin
          tick(1);
          n = n + core_int[k];
        end
      end
    join
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures = failures + 1;
      results;
    end
  end
  initial begin
    tick(10);
    check({core_rst_n, host, flag, fl_pin_oe}, 11'h300);
    @(posedge clk) rst_n <= 1'b1;
    u_rwps_board.hold_reset(3);
    await_run;
    $display("test power-up done");
    for (i = 0; i < 12; i = i + 1) begin
      @(posedge clk);
      r = nx(r);
      keep_d <= {r, ~r};
      fl_d <= {r[3:0], r[7:4]};
      fl_oe <= ~r;
      f_set <= r[0];
      f_clr <= r[1];
      h_req <= r[2];
      ef = r[0] | (ef & ~r[1]);
      tick(2);
      check(keep, {r, ~r});
      check({host, flag, fl_pin, fl_pin_oe}, {~r[2], ef, r[3:0], r[7:4], ~r});
    end
    $display("test random run done");
    @(posedge clk);
    fl_oe <= 8'hFF;
    h_req <= 1'b1;
    f_set <= 1'b0;
    f_clr <= 1'b1;
    fork
      u_rwps_board.hold_reset(12);
      begin
        tick(7);
        kv = keep;
        check({host, flag, fl_pin_oe}, 10'h300);
        @(posedge clk) keep_d <= ~kv;
        tick(2);
        check(keep, kv);
      end
    join
    await_run;
    @(posedge clk) h_req <= 1'b0;
    $display("test warm reset done");
    for (i = 0; i < 4; i = i + 1) begin
      int_seq(i % 2, (i < 2) ? 3 : 2, 16);
      check(n, (i < 2) ? 1 : 0);
    end
    $display("test interrupts done");
    @(posedge clk) cpu_idle <= 1'b1;
    tick(3);
    check(cpu_en, 1'b0);
    @(posedge clk) cpu_idle <= 1'b0;
    int_seq(0, 3, 16);
    check(cpu_en, 1'b1);
    $display("test cpu idle done");
    @(posedge clk) clk_idle <= 1'b1;
    tick(3);
    check(gen_en, 1'b0);
    @(posedge clk) clk_idle <= 1'b0;
    int_seq(0, 40, 46);
    check({gen_en, cpu_en, n >= 4}, 3'h7);
    int_seq(0, 8, 20);
    check(n, 1);
    $display("test clock idle done");
    results;
  end
endmodule // rwps_sequencer_bench
